// ### verilog/iac_pkg.sv
// Constants and types shared by the interrupt acceptance block
package iac_pkg;
    //----------------------------------------------------------------
    // Sources and vectors
    //----------------------------------------------------------------
    localparam int NSRC = 6;
    localparam int NVEC = 5;
    // Source bit positions in the request and gate registers
    localparam int SRC_BASE_TIMER = 0;
    localparam int SRC_EXT_PIN4   = 1;
    localparam int SRC_EXT_PIN0   = 2;
    localparam int SRC_EXT_PIN1   = 3;
    localparam int SRC_SERIAL     = 4;
    localparam int SRC_TIMER0     = 5;
    // Sources behind each vector, vector 0 first; vector 0 is shared
    localparam logic [5:0] VEC_SRC_MASK [NVEC] = '{6'h03, 6'h04, 6'h08, 6'h10, 6'h20};
    // Value of the high level select field that names no vector
    localparam logic [2:0] HL_NONE = 3'h7;

    //----------------------------------------------------------------
    // Timing, nesting status codes and reset values
    //----------------------------------------------------------------
    localparam logic [1:0] ACC_CYCLES = 2'h3;
    localparam logic [1:0] NEST_IDLE  = 2'h0;
    localparam logic [1:0] NEST_ONE   = 2'h1;
    localparam logic [1:0] NEST_TWO   = 2'h2;
    localparam logic [9:0] VBANK_RST  = 10'h000;
    localparam logic [3:0] EDGE_RST   = 4'h0;

    //----------------------------------------------------------------
    // Register byte offsets and field positions
    //----------------------------------------------------------------
    localparam logic [4:0] REG_REQ    = 5'h00;
    localparam logic [4:0] REG_GATE   = 5'h04;
    localparam logic [4:0] REG_GLOBAL = 5'h08;
    localparam logic [4:0] REG_HLSEL  = 5'h0C;
    localparam logic [4:0] REG_EDGE   = 5'h10;
    localparam logic [4:0] REG_NEST   = 5'h14;
    localparam logic [4:0] REG_VBANK  = 5'h18;
    localparam logic [4:0] REG_STAT   = 5'h1C;
    localparam int HLSEL_GLOBAL_BIT   = 3;

    typedef enum logic {IAC_IDLE, IAC_PUSH} iac_state_t;
endpackage : iac_pkg

// ### verilog/iac_pick_if.sv
// Interface between the acceptance logic and the vector priority picker
`timescale 1ns/100ps
interface iac_pick_if #(parameter int NVEC = 5);
    logic [NVEC-1:0] vec_req;
    logic            pick_valid;
    logic [2:0]      pick_idx;
    modport ctrl (output vec_req, input pick_valid, input pick_idx);
    modport pick (input vec_req, output pick_valid, output pick_idx);
endinterface : iac_pick_if

// ### verilog/iac_pick.sv
// Fixed priority picker: lowest requesting vector wins
`timescale 1ns/100ps
module iac_pick #(
    parameter int NVEC = 5
) (
    iac_pick_if.pick pif
);
    // Scan from the lowest priority upward so the highest one wins
    always_comb begin
        pif.pick_valid = 1'b0;
        pif.pick_idx   = 3'h0;
        for (int i = NVEC - 1; i >= 0; i--) begin
            if (pif.vec_req[i]) begin
                pif.pick_valid = 1'b1;
                pif.pick_idx   = 3'(i);
            end
        end
    end
endmodule : iac_pick

// ### verilog/iac_accept.sv
// Interrupt acceptance, gating, nesting and register file
// Functional notes
// - Flag set during interrupt-control op: one more instruction, then 3 cycles.
// - Consecutive interrupt-control ops all run; acceptance waits past the last.
// - Mask-all at or after flag set keeps request pending until unmask-all.
// - Interrupt-control ops are those touching interrupt hardware, incl mask/unmask.
// - Three acceptance cycles perform the stack writes.
// - Flag set in final cycle: one more instruction, then 3 acceptance cycles.
// - Flag set earlier: acceptance right after the current instruction.
// - Following interrupt-control ops extend the wait past the last plus one.
// - Software-set request flag behaves like hardware-set flag.
// - Entry loads data and register bank gates from the vector entry.
// - Reset disables all interrupts and sets nesting status 0.
// - Acceptance needs both source gate and global gate.
// - Clearing a source gate blocks that source; mask-all blocks all.
// - Low-priority acceptance from status 0 enters status 1, others pend.
// - High-priority source nests in status 1; then nothing until return.
// - Service return restores the nesting status held before acceptance.
// - One write to high level select may also set global gate.
// - Acceptance advances nesting 00 to 01 or 01 to 10.
// - Status 1 admits only high-priority source; status 2 admits none.
// - Program counter and status word pushed before vector load.
// - Shared vector with both gates set leaves both flags standing.
//
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/100ps
module iac_accept #(
    parameter int NSRC = 6,
    parameter int NVEC = 5
) (
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    // Avalon-MM slave
    input  wire logic [4:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    input  wire logic [3:0]       avs_byteenable,
    output logic      [31:0]      avs_readdata,
    output logic                  avs_waitrequest,
    // Instruction sequencer
    input  wire logic             cyc_last,
    input  wire logic             cyc_ictl,
    input  wire logic             seq_mask_all,
    input  wire logic             seq_unmask_all,
    input  wire logic             seq_return,
    // Interrupt sources
    input  wire logic [NSRC-1:0]  src_event,
    // Acceptance answer
    output logic                  acc_busy,
    output logic                  acc_push,
    output logic      [1:0]       acc_step,
    output logic      [2:0]       acc_vector,
    output logic                  vector_load,
    output logic                  data_bank_gate,
    output logic                  regset_bank_gate,
    output logic      [1:0]       nest_state,
    output logic      [1:0]       ext_pin0_edge_mode,
    output logic      [1:0]       ext_pin1_edge_mode
);
    //----------------------------------------------------------------
    // State
    //----------------------------------------------------------------
    logic [NSRC-1:0]     source_request_flag;
    logic [NSRC-1:0]     source_gate_flag;
    logic                global_gate_flag;
    logic [2:0]          high_level_source_select;
    logic [1:0]          nest_save0;
    logic [1:0]          nest_save1;
    logic [2*NVEC-1:0]   vbank;
    logic                seen_early;
    logic                defer;
    logic [1:0]          acc_cnt;
    iac_pkg::iac_state_t state;

    iac_pick_if #(.NVEC(NVEC)) pif ();

    iac_pick #(.NVEC(NVEC)) u_pick (
        .pif (pif)
    );

    //----------------------------------------------------------------
    // Bus decode
    //----------------------------------------------------------------
    wire        bus_take   = ~avs_waitrequest & (avs_read | avs_write);
    wire        wr_take    = bus_take & avs_write;
    wire [31:0] wmask      = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                              {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [31:0] wd_masked  = avs_writedata & wmask;
    wire        wr_req     = wr_take & (avs_address == iac_pkg::REG_REQ);
    wire        wr_gate    = wr_take & (avs_address == iac_pkg::REG_GATE);
    wire        wr_global  = wr_take & (avs_address == iac_pkg::REG_GLOBAL);
    wire        wr_hlsel   = wr_take & (avs_address == iac_pkg::REG_HLSEL);
    wire        wr_edge    = wr_take & (avs_address == iac_pkg::REG_EDGE);
    wire        wr_nest    = wr_take & (avs_address == iac_pkg::REG_NEST);
    wire        wr_vbank   = wr_take & (avs_address == iac_pkg::REG_VBANK);
    wire        be0        = avs_byteenable[0];

    // Read data selection
    logic [31:0] rd_mux;
    always_comb begin
        if (avs_address == iac_pkg::REG_REQ)
            rd_mux = 32'(source_request_flag);
        else if (avs_address == iac_pkg::REG_GATE)
            rd_mux = 32'(source_gate_flag);
        else if (avs_address == iac_pkg::REG_GLOBAL)
            rd_mux = 32'(global_gate_flag);
        else if (avs_address == iac_pkg::REG_HLSEL)
            rd_mux = 32'(high_level_source_select);
        else if (avs_address == iac_pkg::REG_EDGE)
            rd_mux = 32'({ext_pin1_edge_mode, ext_pin0_edge_mode});
        else if (avs_address == iac_pkg::REG_NEST)
            rd_mux = 32'(nest_state);
        else if (avs_address == iac_pkg::REG_VBANK)
            rd_mux = 32'(vbank);
        else if (avs_address == iac_pkg::REG_STAT)
            rd_mux = 32'({defer, acc_busy});
        else
            rd_mux = 32'h0000_0000;
    end

    // One wait cycle, then the answer stands for one cycle
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= ~(avs_waitrequest & (avs_read | avs_write));
            avs_readdata    <= rd_mux;
        end
    end

    //----------------------------------------------------------------
    // Gating and priority
    //----------------------------------------------------------------
    wire [NSRC-1:0] src_live = source_request_flag & source_gate_flag
                               & {NSRC{global_gate_flag}};
    // Any request behind an open source gate, watched by the gate check
    wire            gated_any = |(source_request_flag & source_gate_flag);
    logic [NVEC-1:0] vec_permit;
    always_comb begin
        for (int v = 0; v < NVEC; v++) begin
            if (nest_state == iac_pkg::NEST_IDLE)
                vec_permit[v] = 1'b1;
            else if (nest_state == iac_pkg::NEST_ONE)
                vec_permit[v] = (high_level_source_select == 3'(v));
            else
                vec_permit[v] = 1'b0;
        end
    end

    // Requests per vector; shared vector ORs both sources
    always_comb begin
        for (int v = 0; v < NVEC; v++)
            pif.vec_req[v] = |(src_live & iac_pkg::VEC_SRC_MASK[v]) & vec_permit[v];
    end

    wire             idle     = (state == iac_pkg::IAC_IDLE);
    wire             eligible = pif.pick_valid & idle;
    wire             go       = idle & cyc_last & ~cyc_ictl & eligible
                                & (seen_early | defer);

    // Flags cleared on acceptance unless a shared vector has both gates set
    wire [NSRC-1:0]  clr_cand = iac_pkg::VEC_SRC_MASK[pif.pick_idx] & source_gate_flag;
    wire             both_on  = |(clr_cand & (clr_cand - NSRC'(1)));
    wire [NSRC-1:0]  clr_bits = (go & ~both_on) ? clr_cand : '0;

    //----------------------------------------------------------------
    // Deferral tracking
    //----------------------------------------------------------------
    // Early sighting arms acceptance at the end of this same instruction
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            seen_early <= 1'b0;
            defer      <= 1'b0;
        end else begin
            if (cyc_last | ~idle)
                seen_early <= 1'b0;
            else if (eligible & ~cyc_ictl)
                seen_early <= 1'b1;
            if (~idle | go | (cyc_last & ~eligible))
                defer <= 1'b0;
            else if (cyc_last & eligible)
                defer <= 1'b1;
        end
    end

    //----------------------------------------------------------------
    // Acceptance sequence
    //----------------------------------------------------------------
    // Three push cycles, then the vector load pulse
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state       <= iac_pkg::IAC_IDLE;
            acc_cnt     <= 2'h0;
            acc_vector  <= 3'h0;
            vector_load <= 1'b0;
        end else begin
            vector_load <= 1'b0;
            case (state)
                iac_pkg::IAC_IDLE: begin
                    acc_cnt <= 2'h0;
                    if (go) begin
                        state      <= iac_pkg::IAC_PUSH;
                        acc_vector <= pif.pick_idx;
                    end
                end
                iac_pkg::IAC_PUSH: begin
                    acc_cnt <= acc_cnt + 2'h1;
                    if (acc_cnt == iac_pkg::ACC_CYCLES - 2'h1) begin
                        state       <= iac_pkg::IAC_IDLE;
                        vector_load <= 1'b1;
                    end
                end
                default: state <= iac_pkg::IAC_IDLE;
            endcase
        end
    end

    // Stack write strobes: steps 0 and 1 program counter, step 2 status word
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            acc_busy <= 1'b0;
            acc_push <= 1'b0;
            acc_step <= 2'h0;
        end else begin
            acc_busy <= go | (~idle & (acc_cnt != iac_pkg::ACC_CYCLES - 2'h1));
            acc_push <= go | (~idle & (acc_cnt != iac_pkg::ACC_CYCLES - 2'h1));
            acc_step <= go ? 2'h0 : acc_step + 2'h1;
        end
    end

    wire acc_end = ~idle & (acc_cnt == iac_pkg::ACC_CYCLES - 2'h1);

    //----------------------------------------------------------------
    // Nesting status and its save stack
    //----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            nest_state <= iac_pkg::NEST_IDLE;
            nest_save0 <= iac_pkg::NEST_IDLE;
            nest_save1 <= iac_pkg::NEST_IDLE;
        end else if (acc_end) begin
            nest_state <= nest_state + 2'h1;
            nest_save0 <= nest_state;
            nest_save1 <= nest_save0;
        end else if (seq_return & idle) begin
            nest_state <= nest_save0;
            nest_save0 <= nest_save1;
        end else if (wr_nest & be0) begin
            nest_state <= avs_writedata[1:0];
        end
    end

    // Bank gates loaded from the accepted vector entry
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            data_bank_gate   <= 1'b0;
            regset_bank_gate <= 1'b0;
        end else if (acc_end) begin
            data_bank_gate   <= vbank[2*acc_vector];
            regset_bank_gate <= vbank[2*acc_vector+1];
        end
    end

    //----------------------------------------------------------------
    // Software registers
    //----------------------------------------------------------------
    wire [NSRC-1:0] next_flag = wr_req
        ? ((source_request_flag & ~wmask[NSRC-1:0]) | wd_masked[NSRC-1:0])
        : (source_request_flag & ~clr_bits);
    // Source events win over any clear in the same cycle
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            source_request_flag <= '0;
        else
            source_request_flag <= next_flag | src_event;
    end

    // Gates, select, edge modes and vector bank bits
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            source_gate_flag         <= '0;
            high_level_source_select <= iac_pkg::HL_NONE;
            {ext_pin1_edge_mode, ext_pin0_edge_mode} <= iac_pkg::EDGE_RST;
            vbank                    <= iac_pkg::VBANK_RST;
        end else begin
            if (wr_gate & be0)
                source_gate_flag <= avs_writedata[NSRC-1:0];
            if (wr_hlsel & be0)
                high_level_source_select <= avs_writedata[2:0];
            if (wr_edge & be0)
                {ext_pin1_edge_mode, ext_pin0_edge_mode} <= avs_writedata[3:0];
            if (wr_vbank)
                vbank <= (vbank & ~wmask[2*NVEC-1:0]) | wd_masked[2*NVEC-1:0];
        end
    end

    // Global gate: sequencer ops first, then register writes
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            global_gate_flag <= 1'b0;
        else if (seq_mask_all)
            global_gate_flag <= 1'b0;
        else if (seq_unmask_all)
            global_gate_flag <= 1'b1;
        else if (wr_global & be0)
            global_gate_flag <= avs_writedata[0];
        else if (wr_hlsel & be0 & avs_writedata[iac_pkg::HLSEL_GLOBAL_BIT])
            global_gate_flag <= 1'b1;
    end

    //----------------------------------------------------------------
    // Assertions
    //----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    accept_len_a: assert property ($rose(acc_busy) |-> acc_busy [*3] ##1 !acc_busy)
        else $error("acceptance not three cycles");
    vec_after_push_a: assert property ($fell(acc_busy) |-> vector_load && !acc_push)
        else $error("vector load not after pushes");
    nest_adv_a: assert property (vector_load |->
        (nest_state == 2'h1 && $past(nest_state) == 2'h0) ||
        (nest_state == 2'h2 && $past(nest_state) == 2'h1))
        else $error("nesting did not advance");
    gate_need_a: assert property ($rose(acc_busy) |->
        $past(global_gate_flag) && $past(gated_any))
        else $error("accepted without gates");
    status_two_a: assert property ($rose(acc_busy) |-> $past(nest_state) != 2'h2)
        else $error("accepted in status 2");
    status_one_a: assert property ($rose(acc_busy) && $past(nest_state) == 2'h1 |->
        acc_vector == $past(high_level_source_select))
        else $error("low priority nested");
    ictl_defer_a: assert property ($rose(acc_busy) |->
        $past(cyc_last) && !$past(cyc_ictl))
        else $error("accepted inside control op");
    late_flag_a: assert property (idle && cyc_last && !cyc_ictl && eligible
        && !seen_early && !defer |=> !acc_busy ##0 defer)
        else $error("late flag accepted early");
    return_rest_a: assert property (seq_return && idle && !acc_end |=>
        nest_state == $past(nest_save0))
        else $error("return did not restore status");
    mask_pend_a: assert property (seq_mask_all && idle |=> !acc_busy [*2])
        else $error("accepted after mask-all");

    nested_c: cover property (vector_load && nest_state == 2'h2);
    deferred_c: cover property (defer ##[1:8] $rose(acc_busy));
    shared_keep_c: cover property (go && both_on);
    return_c: cover property (seq_return && nest_state == 2'h2);
endmodule : iac_accept

// ### verif/iac_seq_model.sv
// Behavioural instruction sequencer that marks machine cycles
`timescale 1ns/100ps
module iac_seq_model (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic       acc_busy,
    input  wire logic       restart,
    input  wire logic [7:0] len_pat,
    input  wire logic [3:0] ctl_pat,
    output logic            cyc_last,
    output logic            cyc_ictl
);
    logic [1:0] left;
    logic [1:0] idx;
    logic [1:0] next_idx;
    // Core stalls during acceptance; no instruction ends while restarting
    assign next_idx = idx + 2'h1;
    assign cyc_last = (left == 2'h1) && !acc_busy && !restart;
    assign cyc_ictl = ctl_pat[idx] && !acc_busy && !restart;
    // Countdown of the cycles left in the current instruction
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            idx  <= 2'h0;
            left <= 2'h1;
        end else if (restart) begin
            idx  <= 2'h0;
            left <= len_pat[1:0];
        end else if (cyc_last) begin
            idx  <= next_idx;
            left <= len_pat[2*next_idx +: 2];
        end else if (!acc_busy) begin
            left <= left - 2'h1;
        end
    end
endmodule : iac_seq_model

// ### verif/interrupt_accept_timing_nesting_bench.sv
// Self-checking bench for interrupt acceptance timing and nesting
`timescale 1ns/100ps
module interrupt_accept_timing_nesting_bench;
    logic        ref_clk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic        seq_mask_all = 1'b0, seq_unmask_all = 1'b0, seq_return = 1'b0;
    logic        restart = 1'b0, avs_waitrequest, cyc_last, cyc_ictl, acc_busy, acc_push;
    logic        vector_load, data_bank_gate, regset_bank_gate;
    logic [5:0]  src_event = 6'h00;
    logic [1:0]  acc_step, nest_state, ext_pin0_edge_mode, ext_pin1_edge_mode;
    logic [2:0]  acc_vector;
    logic [7:0]  len_pat = 8'hE6;
    logic [3:0]  ctl_pat = 4'h0;
    logic [9:0]  vbank;
    logic [7:0]  lens [4] = '{8'hE6, 8'hE5, 8'hE6, 8'hE5};
    logic [3:0]  ctls [4] = '{4'h0, 4'h0, 4'h1, 4'h3};
    int          ends_exp [4] = '{1, 2, 2, 3};
    logic [31:0] exp_rd [$];
    logic [6:0]  exp_acc [$];
    int          exp_ends [$];
    int          fails = 0, total_checks = 0, cycles = 0, ends = 0, stp = 0, e;
    logic        busy_d = 1'b0, vl_d = 1'b0;
    integer      seed = 57948;

    iac_accept #(.NSRC(iac_pkg::NSRC), .NVEC(iac_pkg::NVEC)) u_dut (
        .ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .cyc_last(cyc_last), .cyc_ictl(cyc_ictl), .seq_mask_all(seq_mask_all),
        .seq_unmask_all(seq_unmask_all), .seq_return(seq_return), .src_event(src_event),
        .acc_busy(acc_busy), .acc_push(acc_push), .acc_step(acc_step),
        .acc_vector(acc_vector), .vector_load(vector_load), .data_bank_gate(data_bank_gate),
        .regset_bank_gate(regset_bank_gate), .nest_state(nest_state),
        .ext_pin0_edge_mode(ext_pin0_edge_mode), .ext_pin1_edge_mode(ext_pin1_edge_mode));

    iac_seq_model u_seq (.ref_clk(ref_clk), .resetn(resetn), .acc_busy(acc_busy),
        .restart(restart), .len_pat(len_pat), .ctl_pat(ctl_pat), .cyc_last(cyc_last),
        .cyc_ictl(cyc_ictl));

    // Clock of 100 ns period
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic cmp_val(input string what, input logic [31:0] x, input logic [31:0] got);
        total_checks++;
        if (got !== x) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, x, got);
        end
    endtask : cmp_val

    task automatic end_of_test;
        if (exp_acc.size() != 0 || exp_rd.size() != 0 || exp_ends.size() != 0) fails++;
        $display("checks %0d errors %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test

    // One Avalon-MM transfer; a read notes its expected data
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        if (!wr) exp_rd.push_back(d);
        // Ends once avs_waitrequest reads 0; only the bench timeout ends a hang
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    // One-cycle pulses of source events, sequencer ops and restart
    task automatic kick(input logic [5:0] ev, input logic [2:0] op, input logic rs);
        @(posedge ref_clk);
        src_event <= ev;
        {seq_mask_all, seq_unmask_all, seq_return} <= op;
        restart <= rs;
        @(posedge ref_clk);
        src_event <= 6'h00;
        {seq_mask_all, seq_unmask_all, seq_return} <= 3'h0;
        restart <= 1'b0;
    endtask : kick

    task automatic accept(input int n, input logic [2:0] v, input logic [1:0] s);
        exp_ends.push_back(n);
        exp_acc.push_back({v, s, vbank[2*v], vbank[2*v+1]});
    endtask : accept

    task automatic wait_load;
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (vector_load !== 1'b1 && n < 60);
        if (vector_load !== 1'b1) cmp_val("vector_load", 32'h1, 32'h0);
        repeat (2) @(posedge ref_clk);
    endtask : wait_load

    // Scoreboard: read data, acceptance timing, stack steps, routine entry
    always @(posedge ref_clk) begin
        if (avs_read && avs_waitrequest === 1'b0 && exp_rd.size() > 0)
            cmp_val("readdata", exp_rd.pop_front(), avs_readdata);
        if (acc_busy === 1'b1 && !busy_d) begin
            if (exp_ends.size() == 0) cmp_val("acc_busy", 32'h0, 32'h1);
            else begin
                e = exp_ends.pop_front();
                if (e >= 0) cmp_val("instruction ends", 32'(e), 32'(ends));
            end
        end
        if (acc_push === 1'b1) begin
            cmp_val("acc_step", 32'(stp), {30'h0, acc_step});
            stp++;
        end else stp = 0;
        if (vl_d && exp_acc.size() > 0)
            cmp_val("entry", 32'(exp_acc.pop_front()), {25'h0, acc_vector, nest_state,
                data_bank_gate, regset_bank_gate});
        busy_d = (acc_busy === 1'b1);
        vl_d = (vector_load === 1'b1);
        if (restart) ends = 0;
        else if (cyc_last === 1'b1) ends++;
    end

    // Main sequence
    initial begin
        vbank = 10'($random(seed));
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        bus(1'b0, iac_pkg::REG_REQ, 32'h0);
        bus(1'b0, iac_pkg::REG_GATE, 32'h0);
        bus(1'b0, iac_pkg::REG_GLOBAL, 32'h0);
        bus(1'b0, iac_pkg::REG_HLSEL, 32'(iac_pkg::HL_NONE));
        bus(1'b0, iac_pkg::REG_NEST, 32'h0);
        bus(1'b1, iac_pkg::REG_STAT, 32'hFFFFFFFF);
        bus(1'b0, iac_pkg::REG_STAT, 32'h0);
        bus(1'b1, iac_pkg::REG_GATE, 32'h20);
        bus(1'b1, iac_pkg::REG_EDGE, 32'h9);
        @(posedge ref_clk);
        cmp_val("edge modes", 32'h9, {28'h0, ext_pin1_edge_mode, ext_pin0_edge_mode});
        bus(1'b1, iac_pkg::REG_VBANK, {22'h0, vbank});
        kick(6'h20, 3'h0, 1'b1);
        repeat (30) @(posedge ref_clk);
        bus(1'b0, iac_pkg::REG_REQ, 32'h20);
        accept(-1, 3'h4, 2'h1);
        bus(1'b1, iac_pkg::REG_HLSEL, 32'hF);
        wait_load();
        bus(1'b0, iac_pkg::REG_GLOBAL, 32'h1);
        kick(6'h00, 3'h1, 1'b0);
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            len_pat <= lens[i];
            ctl_pat <= ctls[i];
            accept(ends_exp[i], 3'h4, 2'h1);
            kick(6'h20, 3'h0, 1'b1);
            wait_load();
            bus(1'b0, iac_pkg::REG_REQ, 32'h0);
            kick(6'h00, 3'h1, 1'b0);
        end
        kick(6'h20, 3'h4, 1'b1);
        repeat (30) @(posedge ref_clk);
        accept(-1, 3'h4, 2'h1);
        kick(6'h00, 3'h2, 1'b0);
        wait_load();
        kick(6'h00, 3'h1, 1'b0);
        accept(-1, 3'h4, 2'h1);
        bus(1'b1, iac_pkg::REG_REQ, 32'h20);
        wait_load();
        kick(6'h00, 3'h1, 1'b0);
        bus(1'b1, iac_pkg::REG_GATE, 32'h34);
        bus(1'b1, iac_pkg::REG_HLSEL, 32'h1);
        accept(-1, 3'h4, 2'h1);
        kick(6'h20, 3'h0, 1'b0);
        wait_load();
        kick(6'h10, 3'h0, 1'b0);
        repeat (20) @(posedge ref_clk);
        accept(-1, 3'h1, 2'h2);
        kick(6'h04, 3'h0, 1'b0);
        wait_load();
        kick(6'h04, 3'h0, 1'b0);
        repeat (20) @(posedge ref_clk);
        accept(-1, 3'h1, 2'h2);
        kick(6'h00, 3'h1, 1'b0);
        wait_load();
        kick(6'h00, 3'h1, 1'b0);
        bus(1'b0, iac_pkg::REG_NEST, 32'h1);
        accept(-1, 3'h3, 2'h1);
        kick(6'h00, 3'h1, 1'b0);
        wait_load();
        kick(6'h00, 3'h1, 1'b0);
        bus(1'b1, iac_pkg::REG_GATE, 32'h03);
        accept(-1, 3'h0, 2'h1);
        kick(6'h03, 3'h0, 1'b0);
        wait_load();
        bus(1'b0, iac_pkg::REG_REQ, 32'h3);
        bus(1'b1, iac_pkg::REG_REQ, 32'h0);
        kick(6'h00, 3'h1, 1'b0);
        bus(1'b0, iac_pkg::REG_NEST, 32'h0);
        repeat (20) @(posedge ref_clk);
        end_of_test();
    end

    // Cuts a hung run short
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 8000) begin
            fails++;
            end_of_test();
        end
    end
endmodule : interrupt_accept_timing_nesting_bench
